// File: logic/ext_bus_strobe_ctrl.sv
`timescale 1ns/100ps
`include "ext_bus_cfg.svh"

module ext_bus_strobe_ctrl
  import ext_bus_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // Static configuration
  input  wire logic                  split_strobe_mode,
  input  wire logic                  mux_mode,
  input  wire logic                  bus16,
  input  wire logic                  area_sel_en,
  // Core side
  input  wire logic                  req_valid,
  output      logic                  req_ready,
  input  wire bus_req_t              req,
  output      logic                  resp_valid,
  output      logic [`DATA_W-1:0]    resp_rdata,
  // External pins
  output      logic                  bclk,
  output      logic [`ADDR_W-1:0]    addr_out,
  output      logic                  addr_oe_n,
  output      logic [`DATA_W-1:0]    data_out,
  output      logic                  data_oe_n,
  input  wire logic [`DATA_W-1:0]    data_in,
  output      logic                  store_strobe_even_n,
  output      logic                  store_strobe_odd_n,
  output      logic                  fetch_strobe_n,
  output      logic                  address_latch_pulse,
  output      logic                  ctrl_oe_n,
  input  wire logic                  bus_release_request_n,
  output      logic                  bus_release_ack_n,
  input  wire logic                  wait_request_n,
  output      logic                  hold_state
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_END, ST_HOLD} bus_state_t;

  // ----------------------------------------------------------------
  // Area select decode
  // ----------------------------------------------------------------
  function automatic logic [`AREA_W-1:0] area_decode(input logic [`ADDR_W-1:0] a);
    logic [`AREA_W-1:0] sel_n;
    sel_n = '1;
    sel_n[a[`AREA_SEL_HI:`AREA_SEL_LO]] = 1'b0;
    return sel_n;
  endfunction : area_decode

  bus_state_t                  state_ff;
  bus_state_t                  nxt_state;
  bus_req_t                    cur_ff;
  logic [`BCLK_CNT_W-1:0]      div_ff;
  logic                        bclk_ff;
  logic                        rise_tick;
  logic [`DATA_W+1:0]          pin_sync;
  logic                        hold_req_s;
  logic                        wait_s;
  logic [`DATA_W-1:0]          data_in_s;
  logic                        resp_valid_ff;
  logic [`DATA_W-1:0]          rdata_ff;
  strobe_t                     strb;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  sync_two_ff #(
    .WIDTH   (`DATA_W+2),
    .RST_VAL ({2'b11, {`DATA_W{1'b0}}})
  ) u_pin_sync (
    .mclk (mclk),
    .rst_b(rst_b),
    .din  ({bus_release_request_n, wait_request_n, data_in}),
    .dout (pin_sync)
  );

  assign hold_req_s = ~pin_sync[`DATA_W+1];
  assign wait_s     = ~pin_sync[`DATA_W];
  assign data_in_s  = pin_sync[`DATA_W-1:0];

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  // The bus is stepped only on the bus clock rising edge, so every
  // phase lasts a whole number of bus clock periods seen by external logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff  <= '0;
      bclk_ff <= 1'b0;
    end else if (div_ff == `BCLK_CNT_W'(`BCLK_HALF_CYC - 1)) begin
      div_ff  <= '0;
      bclk_ff <= ~bclk_ff;
    end else begin
      div_ff  <= div_ff + 1'b1;
    end
  end

  assign rise_tick = (div_ff == `BCLK_CNT_W'(`BCLK_HALF_CYC - 1)) && !bclk_ff;
  assign bclk      = bclk_ff;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  // Hold is granted only between cycles so an access is never torn
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (hold_req_s) begin
          nxt_state = ST_HOLD;
        end else if (req_valid) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR:   nxt_state = ST_STROBE;
      ST_STROBE: begin
        if (!wait_s) begin
          nxt_state = ST_END;
        end
      end
      ST_END:    nxt_state = ST_IDLE;
      ST_HOLD: begin
        if (!hold_req_s) begin
          nxt_state = ST_IDLE;
        end
      end
      default:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else if (rise_tick) begin
      state_ff <= nxt_state;
    end
  end

  // Request accepted on the bus clock edge that leaves idle
  assign req_ready = rise_tick && (state_ff == ST_IDLE) && !hold_req_s;

  // Request is held for the whole cycle so pins stay stable in waits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else if (req_valid && req_ready) begin
      cur_ff <= req;
    end
  end

  // ----------------------------------------------------------------
  // Read capture and response
  // ----------------------------------------------------------------
  // Data is taken on the last edge of the strobe phase, still inside it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff      <= '0;
      resp_valid_ff <= 1'b0;
    end else begin
      resp_valid_ff <= rise_tick && (state_ff == ST_END);
      if (rise_tick && (state_ff == ST_STROBE) && !wait_s && !cur_ff.write) begin
        rdata_ff <= data_in_s;
      end
    end
  end

  assign resp_valid = resp_valid_ff;
  assign resp_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Strobe generation
  // ----------------------------------------------------------------
  always_comb begin
    strb.ale        = (state_ff == ST_ADDR);
    strb.fetch_n    = !((state_ff == ST_STROBE) && !cur_ff.write);
    strb.strobe_a_n = 1'b1;
    strb.strobe_b_n = 1'b1;
    if (split_strobe_mode) begin
      if ((state_ff == ST_STROBE) && cur_ff.write) begin
        strb.strobe_a_n = !cur_ff.be[0];
        strb.strobe_b_n = !cur_ff.be[1];
      end
    end else begin
      strb.strobe_a_n = !((state_ff == ST_STROBE) && cur_ff.write);
      // Select stands for the whole cycle so it frames the strobe
      if ((state_ff == ST_ADDR) || (state_ff == ST_STROBE) || (state_ff == ST_END)) begin
        strb.strobe_b_n = !cur_ff.be[1];
      end
    end
  end

  // Registered pin drivers: no glitches on the strobes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      store_strobe_even_n <= 1'b1;
      store_strobe_odd_n  <= 1'b1;
      fetch_strobe_n      <= 1'b1;
      address_latch_pulse <= 1'b0;
    end else begin
      store_strobe_even_n <= strb.strobe_a_n;
      store_strobe_odd_n  <= strb.strobe_b_n;
      fetch_strobe_n      <= strb.fetch_n;
      address_latch_pulse <= strb.ale;
    end
  end

  // ----------------------------------------------------------------
  // Address and data pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_out <= '0;
      data_out <= '0;
    end else begin
      addr_out <= cur_ff.addr;
      if (area_sel_en) begin
        addr_out[`AREA_SEL_HI:`HI_ADDR_LO] <= area_decode(cur_ff.addr);
      end
      if (mux_mode && (state_ff == ST_ADDR)) begin
        data_out <= bus16 ? cur_ff.addr[`DATA_W-1:0]
                          : {{`LOW_BYTE_W{1'b0}}, cur_ff.addr[`LOW_BYTE_W-1:0]};
      end else begin
        data_out <= cur_ff.wdata;
      end
    end
  end

  // Enables are active low; data pins drive for the address phase in
  // multiplexed mode and for the strobe phase of a write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_oe_n <= 1'b0;
      ctrl_oe_n <= 1'b0;
      data_oe_n <= 1'b1;
    end else begin
      addr_oe_n <= (state_ff == ST_HOLD);
      ctrl_oe_n <= (state_ff == ST_HOLD);
      data_oe_n <= !((mux_mode && (state_ff == ST_ADDR)) ||
                     (cur_ff.write && (state_ff == ST_STROBE)));
    end
  end

  // ----------------------------------------------------------------
  // Hold acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_release_ack_n <= 1'b1;
      hold_state        <= 1'b0;
    end else begin
      bus_release_ack_n <= (state_ff != ST_HOLD);
      hold_state        <= (state_ff == ST_HOLD);
    end
  end

endmodule : ext_bus_strobe_ctrl

// File: logic/ext_bus_cfg.svh
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// Bus clock half period in mclk cycles (100 MHz / 4 = 25 MHz bus clock)
`define BCLK_HALF_CYC  2
`define BCLK_CNT_W     2
`define ADDR_W         20
`define DATA_W         16
`define AREA_W         4
// Top address bits that pick one of the four access spaces
`define AREA_SEL_HI    19
`define AREA_SEL_LO    18
`define HI_ADDR_LO     16
`define LOW_BYTE_W     8

`endif

// File: logic/ext_bus_pkg.sv
`include "ext_bus_cfg.svh"

package ext_bus_pkg;

  // Request from the core side
  typedef struct packed {
    logic                 write;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
    logic [1:0]           be;      // Bit 1 = odd byte, bit 0 = even byte
  } bus_req_t;

  // Strobe group driven toward the pins
  typedef struct packed {
    logic strobe_a_n;   // Even write strobe, or single write strobe
    logic strobe_b_n;   // Odd write strobe, or upper byte select
    logic fetch_n;
    logic ale;
  } strobe_t;

endpackage : ext_bus_pkg

// File: logic/sync_two_ff.sv
`timescale 1ns/100ps

// Two flip-flop synchroniser for pin inputs; first stage feeds only the second
module sync_two_ff #(
  parameter int          WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  // Both stages reset to the idle level of the pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST_VAL;
      dout    <= RST_VAL;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule : sync_two_ff

// File: tb/ext_bus_strobe_sva.sv
`timescale 1ns/100ps
`include "ext_bus_cfg.svh"
// --------------------------------
// Pin protocol checker
// --------------------------------
module ext_bus_strobe_sva (
  input wire logic               mclk,
  input wire logic               rst_b,
  input wire logic               bclk,
  input wire logic               split_strobe_mode,
  input wire logic               area_sel_en,
  input wire logic               req_ready,
  input wire logic [`ADDR_W-1:0] addr_out,
  input wire logic               addr_oe_n,
  input wire logic               data_oe_n,
  input wire logic               ctrl_oe_n,
  input wire logic               store_strobe_even_n,
  input wire logic               store_strobe_odd_n,
  input wire logic               fetch_strobe_n,
  input wire logic               address_latch_pulse,
  input wire logic               bus_release_ack_n,
  input wire logic               wait_request_n,
  input wire logic               hold_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // One clock of slack on hold entry and exit, as ack and oe follow the state
  AST_ACK_IN_HOLD: assert property (hold_state && $past(hold_state) |-> !bus_release_ack_n)
    else $error("ack not low in hold");
  AST_ACK_IDLE: assert property (!hold_state && !$past(hold_state) |-> bus_release_ack_n)
    else $error("ack low outside hold");
  AST_HIZ_IN_HOLD: assert property (hold_state && $past(hold_state) |->
    addr_oe_n && data_oe_n && ctrl_oe_n)
    else $error("pins driven in hold");
  AST_NO_TAKE_IN_HOLD: assert property (hold_state |-> !req_ready)
    else $error("request taken in hold");
  AST_READ_NO_WRITE: assert property (!fetch_strobe_n |-> store_strobe_even_n &&
    (!split_strobe_mode || store_strobe_odd_n))
    else $error("write strobe during read");
  AST_LATCH_WIDTH: assert property ($rose(address_latch_pulse) |->
    address_latch_pulse[*4] ##1 !address_latch_pulse)
    else $error("latch pulse not one bus clock");
  AST_STROBE_AFTER_LATCH: assert property ($fell(address_latch_pulse) |->
    !fetch_strobe_n || !store_strobe_even_n || !store_strobe_odd_n)
    else $error("no strobe after address phase");
  AST_WAIT_HOLDS_READ: assert property ((!wait_request_n)[*4] ##0 !fetch_strobe_n |=>
    !fetch_strobe_n)
    else $error("read ended under wait");
  AST_ONE_AREA: assert property (area_sel_en && address_latch_pulse |->
    $countones(addr_out[19:16]) == 3)
    else $error("area select not one-hot low");
  // Bus clock spends two mclk high and two low, so each bus phase is a multiple of four mclk
  AST_BCLK_SHAPE: assert property ($rose(bclk) |-> bclk[*2] ##1 (!bclk)[*2] ##1 bclk)
    else $error("bus clock shape wrong");
endmodule : ext_bus_strobe_sva

bind ext_bus_strobe_ctrl ext_bus_strobe_sva u_sva (.mclk, .rst_b, .bclk, .split_strobe_mode,
  .area_sel_en, .req_ready, .addr_out, .addr_oe_n, .data_oe_n, .ctrl_oe_n, .store_strobe_even_n,
  .store_strobe_odd_n, .fetch_strobe_n, .address_latch_pulse, .bus_release_ack_n,
  .wait_request_n, .hold_state);

// File: tb/ext_bus_mem_model.sv
`timescale 1ns/100ps
// --------------------------------
// External memory model
// --------------------------------
module ext_bus_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        mux_mode,
  input  wire logic        bus16,
  input  wire logic        slow,
  input  wire logic [19:0] addr_out,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  input  wire logic        store_strobe_even_n,
  input  wire logic        store_strobe_odd_n,
  input  wire logic        fetch_strobe_n,
  input  wire logic        address_latch_pulse,
  output      logic [15:0] data_in,
  output      logic        wait_request_n,
  output      logic [19:0] lat_addr,
  output      logic [15:0] wr_data,
  output      logic [1:0]  lanes
);
  logic [3:0] wcnt;
  // Data only while read strobe is low; inverse otherwise so stale data never matches
  assign data_in = fetch_strobe_n ? ~(lat_addr[15:0] ^ 16'hA55A)
                                  : lat_addr[15:0] ^ 16'hA55A;
  // Slow device holds wait low for eight clocks after the address phase
  assign wait_request_n = !(slow && wcnt < 4'h8 && !address_latch_pulse);
  // Address capture by latch pulse, lane and write data capture afterwards
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt <= 4'hF;
      lat_addr <= 20'h00000;
      wr_data <= 16'h0000;
      lanes <= 2'h0;
    end else if (address_latch_pulse) begin
      wcnt <= 4'h0;
      // An 8-bit multiplexed bus carries only the low address byte on the data pins
      if (!mux_mode) lat_addr <= addr_out;
      else if (bus16) lat_addr <= {addr_out[19:16], data_out};
      else lat_addr <= {addr_out[19:8], data_out[7:0]};
      lanes <= 2'h0;
    end else begin
      wcnt <= (wcnt == 4'hF) ? wcnt : wcnt + 4'h1;
      if (fetch_strobe_n) lanes <= lanes | {~store_strobe_odd_n, ~store_strobe_even_n};
      if (!data_oe_n) wr_data <= data_out;
    end
  end
endmodule : ext_bus_mem_model

// File: tb/external_bus_strobe_control_test.sv
`timescale 1ns/100ps
`include "ext_bus_cfg.svh"
module external_bus_strobe_control_test;
  import ext_bus_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, split = 1'b1, mux = 1'b0, b16 = 1'b1;
  logic area = 1'b0, slow = 1'b0, req_valid = 1'b0, hreq_n = 1'b1;
  logic req_ready, resp_valid, ack_n, wait_n, hold, ale;
  logic aoe_n, doe_n, coe_n, se_n, so_n, fs_n;
  bus_req_t req = '0;
  logic [15:0] rdata, dout, din, wr_data;
  logic [19:0] aout, lat_addr;
  logic [1:0] lanes;
  int n_errors = 0, num_checks = 0, lat_f, lat_s;

  always #5 mclk = ~mclk;

  ext_bus_strobe_ctrl DUT (.mclk, .rst_b, .split_strobe_mode(split), .mux_mode(mux),
    .bus16(b16), .area_sel_en(area), .req_valid, .req_ready, .req, .resp_valid,
    .resp_rdata(rdata), .bclk(), .addr_out(aout), .addr_oe_n(aoe_n), .data_out(dout),
    .data_oe_n(doe_n), .data_in(din), .store_strobe_even_n(se_n), .store_strobe_odd_n(so_n),
    .fetch_strobe_n(fs_n), .address_latch_pulse(ale), .ctrl_oe_n(coe_n),
    .bus_release_request_n(hreq_n), .bus_release_ack_n(ack_n), .wait_request_n(wait_n),
    .hold_state(hold));
  ext_bus_mem_model u_mem (.mclk, .rst_b, .mux_mode(mux), .bus16(b16), .slow, .addr_out(aout),
    .data_out(dout), .data_oe_n(doe_n), .store_strobe_even_n(se_n), .store_strobe_odd_n(so_n),
    .fetch_strobe_n(fs_n), .address_latch_pulse(ale), .data_in(din), .wait_request_n(wait_n),
    .lat_addr, .wr_data, .lanes);

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Inputs move 1 ns after the rising edge, never on it
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task tmo(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : tmo
  // One bus cycle: request held until taken, then wait for the response
  task bus_op(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] be,
              output int lat);
    int i;
    req = {w, a, d, be};
    req_valid = 1'b1;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) step(1);
    tmo(i, 200);
    step(1);
    req_valid = 1'b0;
    for (lat = 1; lat < 200 && resp_valid !== 1'b1; lat++) step(1);
    tmo(lat, 200);
    step(1);
  endtask : bus_op
  // Byte lanes of writes in either strobe arrangement; single mode runs an 8-bit bus
  task t_writes(input logic sp);
    logic [19:0] a [3];
    logic [1:0]  be [3];
    a = '{20'h01234, 20'h01235, 20'h02460};
    be = '{2'b01, 2'b10, 2'b11};
    split = sp;
    b16 = sp;
    for (int k = 0; k < 3; k++) begin
      bus_op(1'b1, a[k], 16'hC3A5 + k[15:0], be[k], lat_f);
      chk(lanes, sp ? be[k] : {be[k][1], 1'b1});
      chk(lat_addr, a[k]);
      if (sp) chk(wr_data, 16'hC3A5 + k[15:0]);
    end
  endtask : t_writes
  // One read with the chosen bus options, which are put back afterwards
  task t_read(input logic m, input logic ar, input logic sl, input logic [19:0] a,
              output int lat);
    mux = m;
    area = ar;
    slow = sl;
    bus_op(1'b0, a, 16'h0000, 2'b11, lat);
    chk(rdata, a[15:0] ^ 16'hA55A);
    mux = 1'b0;
    area = 1'b0;
    slow = 1'b0;
    // Let an edge pass so a following read sets the options afresh
    step(1);
  endtask : t_read
  // Hold: ack low, pins released, no cycle taken until the request rises
  task t_hold;
    int i;
    hreq_n = 1'b0;
    for (i = 0; i < 50 && hold !== 1'b1; i++) step(1);
    tmo(i, 50);
    step(2);
    chk(ack_n, 1'b0);
    chk({aoe_n, doe_n, coe_n}, 3'h7);
    req = {1'b0, 20'h00100, 16'h0000, 2'b11};
    req_valid = 1'b1;
    for (i = 0; i < 30; i++) begin
      step(1);
      if (req_ready !== 1'b0) chk(req_ready, 1'b0);
    end
    req_valid = 1'b0;
    hreq_n = 1'b1;
    step(1);
    t_read(1'b0, 1'b0, 1'b0, 20'h00100, lat_f);
    chk({ack_n, hold}, 2'b10);
  endtask : t_hold

  initial begin
    step(20);
    rst_b = 1'b1;
    step(2);
    t_writes(1'b1);
    t_writes(1'b0);
    b16 = 1'b1;
    t_read(1'b0, 1'b0, 1'b0, 20'h1ABCD, lat_f);
    t_read(1'b1, 1'b0, 1'b0, 20'h05A3C, lat_f);
    // Multiplexed 8-bit bus: only the low address byte rides on the data pins
    b16 = 1'b0;
    t_read(1'b1, 1'b0, 1'b0, 20'h3C7E1, lat_f);
    chk(lat_addr, 20'h3C7E1);
    b16 = 1'b1;
    t_read(1'b0, 1'b1, 1'b0, 20'h80010, lat_f);
    chk(lat_addr[19:16], 4'hB);
    t_read(1'b0, 1'b0, 1'b1, 20'h00F0E, lat_s);
    chk(lat_s >= lat_f + 4, 1'b1);
    t_hold();
    tally_and_finish();
  end
endmodule : external_bus_strobe_control_test
